// file: hdl/fsw_status_protect.sv
`timescale 1ns/1ps
// What this block does
// [RQ1] Repeated register reads resend byte until deselect
// [RQ2] Busy bit set during writes, cleared after
// [RQ3] While busy, ignore all but register reads/resets/suspend
// [RQ4] Suspend still accepted during program or erase
// [RQ5] Enable latch set/cleared by instructions, reset 0
// [RQ6] Enable latch clears when write completes
// [RQ7] Status write ignores written latch and busy bits
// [RQ8] Program instructions need enable latch set
// [RQ9] Sector and block erases need enable latch
// [RQ10] Status/function/readparam writes need enable latch
// [RQ11] Extended, info-row erase, boot writes need latch
// [RQ12] Volatile register writes need no latch
// [RQ13] Protect field blocks program/erase in region
// [RQ14] Full erase only with protect field zero
// [RQ15] Lock plus low protect pin freezes status while quad bit clear
// [RQ16] Otherwise status write changes stored bits
// [RQ17] Quad bit turns two pins into data
// [RQ18] Stored bits only via status write, default 0
// [RQ19] Table reports power-down exit and entry codes
// [RQ20] Table reports quad enable requirement code
// [RQ21] Protect field maps onto 64 KB blocks
// [RQ22] Each repeated status byte shows live busy
module fsw_status_protect
  import fsw_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC,
  parameter int unsigned ERASE_CYCLES = ERASE_CYC,
  parameter int unsigned NVREG_CYCLES = NVREG_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic wp_n,
  input wire logic hold_rst_n,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic io23_data_mode,
  output logic busy_flag
);

  // Raw pins, two-stage synchronised
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic sck_prev_reg;
  logic cs_prev_reg;
  logic sck_rise, sck_fall, cs_rise, cs_fall;
  logic cs_n_s, mosi_s, wp_n_s, hold_rst_n_s;
  // Frame receive state
  logic [2:0] bit_cnt_reg;
  logic [7:0] byte_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] rx_next;
  logic byte_done;
  logic [7:0] opcode_reg;
  logic [7:0] data1_reg;
  logic [23:0] addr_reg;
  logic ign_reg;
  // Transmit state
  logic [7:0] tx_reg;
  logic [2:0] tx_cnt_reg;
  logic tx_on_reg;
  logic [7:0] pt_addr_reg;
  // Status bits
  logic wel_reg;
  logic [3:0] bp_reg;
  logic quad_reg;
  logic lock_reg;
  logic [7:0] status;
  // Operation engine
  fsw_op_t op_reg;
  fsw_kind_t kind_reg;
  logic [31:0] op_cnt_reg;
  logic [31:0] op_len_reg;
  logic [7:0] pend_status_reg;
  logic op_done;
  logic hw_rst;
  // Frame-end decode results
  logic start_op, wel_set, wel_clr, do_susp, do_res, do_srst;
  fsw_kind_t start_kind;
  logic [31:0] start_len;
  logic blk_prot, locked, busy_ok;

  // Synchroniser pairs, second stage only is used
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Link clock idles low, so no false edge after reset
      pin_meta_reg <= 5'h1E;
      pin_sync_reg <= 5'h1E;
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      pin_meta_reg <= {hold_rst_n, wp_n, spi_mosi, spi_cs_n, spi_sck};
      pin_sync_reg <= pin_meta_reg;
      sck_prev_reg <= pin_sync_reg[0];
      cs_prev_reg <= pin_sync_reg[1];
    end
  end

  assign cs_n_s = pin_sync_reg[1];
  assign mosi_s = pin_sync_reg[2];
  assign wp_n_s = pin_sync_reg[3];
  assign hold_rst_n_s = pin_sync_reg[4];
  // Link edges, only meaningful while selected
  assign sck_rise = pin_sync_reg[0] & ~sck_prev_reg & ~cs_n_s;
  assign sck_fall = ~pin_sync_reg[0] & sck_prev_reg & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_prev_reg;
  assign cs_fall = ~cs_n_s & cs_prev_reg;
  assign rx_next = {rx_reg[6:0], mosi_s};
  assign byte_done = sck_rise && bit_cnt_reg == 3'd7;

  // Pins act as data lines once quad bit is set
  assign hw_rst = ~hold_rst_n_s & ~quad_reg;
  // [RQ15] Hardware lock condition
  assign locked = lock_reg & ~wp_n_s & ~quad_reg;

  // [RQ22] Live status word, busy taken from engine
  assign status = {lock_reg, quad_reg, bp_reg, wel_reg, op_reg == OP_RUN};

  // [RQ3] Instructions still taken while busy
  always_comb begin
    busy_ok = 1'b0;
    case (rx_next)
      CMD_STATUS_READ, CMD_FUNC_READ, CMD_EXT_READ: busy_ok = 1'b1;
      CMD_RESET_ENABLE, CMD_RESET: busy_ok = 1'b1;
      // [RQ4] Suspend accepted despite busy
      CMD_SUSPEND: busy_ok = 1'b1;
      default: busy_ok = 1'b0;
    endcase
  end

  // [RQ21] Region selected by protect field, per 64 KB block
  always_comb begin
    logic [5:0] blk;
    blk = addr_reg[21:16];
    blk_prot = 1'b0;
    if (bp_reg >= 4'd1 && bp_reg <= 4'd6) begin
      blk_prot = blk >= 6'(7'd64 - (7'd1 << (bp_reg - 4'd1)));
    end else if (bp_reg == 4'd7 || bp_reg == 4'd8) begin
      blk_prot = 1'b1;
    end else if (bp_reg >= 4'd9 && bp_reg <= 4'd14) begin
      blk_prot = 7'(blk) < (7'd1 << (4'd14 - bp_reg));
    end else begin
      blk_prot = 1'b0;
    end
  end

  // Receive shifter, byte counter and captured fields
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 3'd0;
      byte_cnt_reg <= 8'h00;
      rx_reg <= 8'h00;
      opcode_reg <= 8'h00;
      data1_reg <= 8'h00;
      addr_reg <= 24'h00_0000;
      ign_reg <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_reg <= 3'd0;
      byte_cnt_reg <= 8'h00;
      ign_reg <= 1'b0;
    end else if (sck_rise) begin
      rx_reg <= rx_next;
      bit_cnt_reg <= bit_cnt_reg + 3'd1;
      if (byte_done) begin
        // Saturate so long frames keep a count
        if (byte_cnt_reg != 8'hFF) begin
          byte_cnt_reg <= byte_cnt_reg + 8'h01;
        end
        if (byte_cnt_reg == 8'h00) begin
          opcode_reg <= rx_next;
          // [RQ3] Frame dropped if busy and not allowed
          ign_reg <= (op_reg == OP_RUN) && !busy_ok;
        end
        if (byte_cnt_reg == 8'h01) begin
          data1_reg <= rx_next;
        end
        if (byte_cnt_reg >= 8'h01 && byte_cnt_reg <= 8'h03) begin
          addr_reg <= {addr_reg[15:0], rx_next};
        end
      end
    end
  end

  // [RQ1] Read data: register byte reloaded until deselect, table address steps on
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= 8'h00;
      tx_cnt_reg <= 3'd0;
      tx_on_reg <= 1'b0;
      pt_addr_reg <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (cs_n_s) begin
      tx_on_reg <= 1'b0;
      spi_miso_oe <= 1'b0;
      tx_cnt_reg <= 3'd0;
    end else if (byte_done && !tx_on_reg) begin
      if (byte_cnt_reg == 8'h00 && rx_next == CMD_STATUS_READ) begin
        tx_reg <= status;
        tx_on_reg <= 1'b1;
      end else if (byte_cnt_reg == 8'h00 && (rx_next == CMD_FUNC_READ ||
                   rx_next == CMD_EXT_READ)) begin
        // Registers outside this block read back as defaults
        tx_reg <= 8'h00;
        tx_on_reg <= 1'b1;
      end else if (opcode_reg == CMD_PARAM_TABLE_READ && !ign_reg &&
                   byte_cnt_reg == ADDR_END_BYTE) begin
        // Dummy byte just ended, first table byte goes out
        tx_reg <= pt_byte(addr_reg[7:0]);
        pt_addr_reg <= addr_reg[7:0] + 8'h01;
        tx_on_reg <= 1'b1;
      end
    end else if (sck_fall && tx_on_reg) begin
      spi_miso <= tx_reg[7];
      spi_miso_oe <= 1'b1;
      tx_cnt_reg <= tx_cnt_reg + 3'd1;
      if (tx_cnt_reg == 3'd7) begin
        if (opcode_reg == CMD_PARAM_TABLE_READ) begin
          tx_reg <= pt_byte(pt_addr_reg);
          pt_addr_reg <= pt_addr_reg + 8'h01;
        end else if (opcode_reg == CMD_STATUS_READ) begin
          // [RQ22] Fresh busy value each repeated byte
          tx_reg <= status;
        end else begin
          tx_reg <= 8'h00;
        end
      end else begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // Parameter table bytes; unlisted locations read as fill
  function automatic logic [7:0] pt_byte(input logic [7:0] a);
    logic [31:0] dpd;
    dpd = {1'b0, DPD_ENTRY_CODE, DPD_EXIT_CODE, 15'h7FFF};
    case (a)
      // [RQ19] Power-down exit and entry codes
      PT_ADDR_DPD_0: pt_byte = dpd[15:8];
      PT_ADDR_DPD_1: pt_byte = dpd[23:16];
      PT_ADDR_DPD_2: pt_byte = dpd[31:24];
      // [RQ20] Quad enable requirement in bits 22:20
      PT_ADDR_QER: pt_byte = {1'b1, QUAD_ENABLE_REQUIREMENT, 4'hF};
      default: pt_byte = PT_FILL;
    endcase
  endfunction : pt_byte

  // Frame-end command decision
  always_comb begin
    start_op = 1'b0;
    start_kind = K_PROG;
    start_len = PROG_CYCLES;
    wel_set = 1'b0;
    wel_clr = 1'b0;
    do_susp = 1'b0;
    do_res = 1'b0;
    do_srst = 1'b0;
    if (cs_rise && !ign_reg && byte_cnt_reg != 8'h00) begin
      case (opcode_reg)
        // [RQ5] Latch set and clear instructions
        CMD_WRITE_ENABLE: wel_set = byte_cnt_reg == 8'h01;
        CMD_WRITE_DISABLE: wel_clr = byte_cnt_reg == 8'h01;
        // [RQ8] Programs need latch; [RQ13] region check on page programs only, not info row
        CMD_PAGE_PROGRAM, CMD_QUAD_PAGE_PROGRAM_A, CMD_QUAD_PAGE_PROGRAM_B: begin
          start_op = wel_reg && byte_cnt_reg > ADDR_END_BYTE && !blk_prot;
        end
        CMD_INFO_ROW_PROGRAM: start_op = wel_reg && byte_cnt_reg > ADDR_END_BYTE;
        // [RQ9] Erases need latch; [RQ13] region check
        CMD_SECTOR_ERASE_A, CMD_SECTOR_ERASE_B, CMD_ERASE_32K, CMD_ERASE_64K: begin
          start_op = wel_reg && byte_cnt_reg == ADDR_END_BYTE && !blk_prot;
          start_kind = K_ERASE;
          start_len = ERASE_CYCLES;
        end
        // [RQ14] Full erase only when protect field is zero
        CMD_FULL_ERASE_A, CMD_FULL_ERASE_B: begin
          start_op = wel_reg && byte_cnt_reg == 8'h01 && bp_reg == 4'h0;
          start_kind = K_ERASE;
          start_len = ERASE_CYCLES;
        end
        // [RQ11] Info row erase needs latch
        CMD_INFO_ROW_ERASE: begin
          start_op = wel_reg && byte_cnt_reg == ADDR_END_BYTE;
          start_kind = K_ERASE;
          start_len = ERASE_CYCLES;
        end
        // [RQ10] [RQ15] [RQ16] Status write: latch, no lock
        CMD_STATUS_WRITE: begin
          start_op = wel_reg && byte_cnt_reg >= 8'h02 && !locked;
          start_kind = K_STATUS;
          start_len = NVREG_CYCLES;
        end
        // [RQ10] [RQ11] Other stored-register writes need latch
        CMD_FUNCTION_WRITE, CMD_READPARAM_NV, CMD_EXT_READPARAM_NV, CMD_BOOT_REG_WRITE: begin
          start_op = wel_reg && byte_cnt_reg >= 8'h02;
          start_kind = K_NVREG;
          start_len = NVREG_CYCLES;
        end
        // [RQ4] Suspend only a running program or erase
        CMD_SUSPEND: do_susp = op_reg == OP_RUN && (kind_reg == K_PROG || kind_reg == K_ERASE);
        CMD_RESUME: do_res = op_reg == OP_SUSP;
        CMD_RESET: do_srst = 1'b1;
        // [RQ12] Volatile writes fall here, accepted without latch
        default: start_op = 1'b0;
      endcase
      // Nothing new starts while busy or suspended
      if (op_reg != OP_IDLE) begin
        start_op = 1'b0;
      end
    end
  end

  assign op_done = op_reg == OP_RUN && op_cnt_reg == op_len_reg - 32'd1;

  // [RQ2] Engine: busy while running, clears at completion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_reg <= OP_IDLE;
      kind_reg <= K_PROG;
      op_cnt_reg <= 32'd0;
      op_len_reg <= 32'd1;
      pend_status_reg <= STATUS_RESET;
    end else if (do_srst || hw_rst) begin
      op_reg <= OP_IDLE;
      op_cnt_reg <= 32'd0;
    end else if (start_op) begin
      op_reg <= OP_RUN;
      kind_reg <= start_kind;
      op_len_reg <= start_len;
      op_cnt_reg <= 32'd0;
      pend_status_reg <= data1_reg;
    end else if (do_susp) begin
      op_reg <= OP_SUSP;
    end else if (do_res) begin
      op_reg <= OP_RUN;
    end else if (op_done) begin
      op_reg <= OP_IDLE;
      op_cnt_reg <= 32'd0;
    end else if (op_reg == OP_RUN) begin
      op_cnt_reg <= op_cnt_reg + 32'd1;
    end
  end

  // Write enable latch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_reg <= 1'b0;
    end else if (do_srst || hw_rst) begin
      wel_reg <= 1'b0;
    end else if (op_done) begin
      // [RQ6] Latch drops as any write completes
      wel_reg <= 1'b0;
    end else if (wel_set) begin
      wel_reg <= 1'b1;
    end else if (wel_clr) begin
      wel_reg <= 1'b0;
    end
  end

  // [RQ18] Stored status bits, changed only by status write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bp_reg <= STATUS_RESET[ST_BP_LO +: 4];
      quad_reg <= STATUS_RESET[ST_QUAD];
      lock_reg <= STATUS_RESET[ST_LOCK];
    end else if (op_done && kind_reg == K_STATUS) begin
      // [RQ7] Latch and busy bits of written byte ignored
      bp_reg <= pend_status_reg[ST_BP_LO +: 4];
      quad_reg <= pend_status_reg[ST_QUAD];
      lock_reg <= pend_status_reg[ST_LOCK];
    end
  end

  // [RQ17] Pin role and busy outputs, registered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      io23_data_mode <= 1'b0;
      busy_flag <= 1'b0;
    end else begin
      io23_data_mode <= quad_reg;
      busy_flag <= status[ST_BUSY];
    end
  end

endmodule : fsw_status_protect

// file: shared/fsw_pkg.sv
package fsw_pkg;
  // Instruction codes seen on the serial link
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_FUNC_READ = 8'h48;
  localparam logic [7:0] CMD_EXT_READ = 8'h81;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_QUAD_PAGE_PROGRAM_A = 8'h32;
  localparam logic [7:0] CMD_QUAD_PAGE_PROGRAM_B = 8'h38;
  localparam logic [7:0] CMD_INFO_ROW_PROGRAM = 8'h62;
  localparam logic [7:0] CMD_SECTOR_ERASE_A = 8'hD7;
  localparam logic [7:0] CMD_SECTOR_ERASE_B = 8'h20;
  localparam logic [7:0] CMD_ERASE_32K = 8'h52;
  localparam logic [7:0] CMD_ERASE_64K = 8'hD8;
  localparam logic [7:0] CMD_FULL_ERASE_A = 8'hC7;
  localparam logic [7:0] CMD_FULL_ERASE_B = 8'h60;
  localparam logic [7:0] CMD_INFO_ROW_ERASE = 8'h64;
  localparam logic [7:0] CMD_FUNCTION_WRITE = 8'h42;
  localparam logic [7:0] CMD_READPARAM_NV = 8'h65;
  localparam logic [7:0] CMD_EXT_READPARAM_NV = 8'h85;
  localparam logic [7:0] CMD_BOOT_REG_WRITE = 8'h15;
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7A;
  localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RESET = 8'h99;
  localparam logic [7:0] CMD_PARAM_TABLE_READ = 8'h5A;
  // Status register layout and reset value
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_QUAD = 6;
  localparam int ST_LOCK = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Parameter table content
  localparam logic [7:0] PT_ADDR_DPD_0 = 8'h65;
  localparam logic [7:0] PT_ADDR_DPD_1 = 8'h66;
  localparam logic [7:0] PT_ADDR_DPD_2 = 8'h67;
  localparam logic [7:0] PT_ADDR_QER = 8'h6A;
  localparam logic [7:0] DPD_EXIT_CODE = 8'hAB;
  localparam logic [7:0] DPD_ENTRY_CODE = 8'hB9;
  localparam logic [2:0] QUAD_ENABLE_REQUIREMENT = 3'b010;
  localparam logic [7:0] PT_FILL = 8'hFF;
  // Frame byte positions
  localparam logic [7:0] PT_DATA_BYTE = 8'h05;
  localparam logic [7:0] ADDR_END_BYTE = 8'h04;
  // Operation times and derived cycle counts at 8 ns
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_US = 800;
  localparam int ERASE_TIME_US = 45000;
  localparam int NVREG_TIME_US = 2000;
  localparam int PROG_CYC = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC = (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NVREG_CYC = (NVREG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Operation engine states and kinds
  typedef enum logic [1:0] {OP_IDLE = 2'b00, OP_RUN = 2'b01, OP_SUSP = 2'b11} fsw_op_t;
  typedef enum logic [1:0] {K_PROG, K_ERASE, K_STATUS, K_NVREG} fsw_kind_t;
endpackage : fsw_pkg

// file: verification/fsw_status_protect_props.sv
`timescale 1ns/1ps
module fsw_status_protect_props
  import fsw_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC,
  parameter int unsigned ERASE_CYCLES = ERASE_CYC,
  parameter int unsigned NVREG_CYCLES = NVREG_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic wp_n,
  input wire logic hold_rst_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic io23_data_mode,
  input wire logic busy_flag
);
  // Sum of all three operation lengths, with slack for the pipeline
  localparam int unsigned MAX_BUSY = ERASE_CYCLES + PROG_CYCLES + NVREG_CYCLES + 4;
  // Cycles of the current busy stretch
  int unsigned busy_cnt_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Counter restarts whenever busy drops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_reg <= 0;
    end else if (busy_flag) begin
      busy_cnt_reg <= busy_cnt_reg + 1;
    end else begin
      busy_cnt_reg <= 0;
    end
  end
  a_oe_deselect: assert property (
    spi_cs_n [*5] |-> !spi_miso_oe) else $error("miso driven while deselected");
  a_oe_selected: assert property (
    $rose(spi_miso_oe) |-> !spi_cs_n) else $error("miso enabled without select");
  a_oe_fall_cause: assert property (
    $fell(spi_miso_oe) |-> spi_cs_n && $past(spi_cs_n, 2)) else $error("read cut short");
  a_busy_after_frame: assert property (
    $rose(busy_flag) |-> spi_cs_n && $past(spi_cs_n, 3)) else $error("busy not after frame");
  a_busy_min_len: assert property (
    $rose(busy_flag) |-> busy_flag [*4]) else $error("busy pulse too short");
  a_busy_bounded: assert property (
    busy_cnt_reg <= MAX_BUSY) else $error("busy never clears");
  a_quad_at_done: assert property (
    $changed(io23_data_mode) |-> !busy_flag && ($past(busy_flag) || $past(busy_flag, 2)))
    else $error("quad bit changed outside a write");
  a_hold_aborts: assert property (
    busy_flag && !hold_rst_n && !io23_data_mode |-> ##[1:6] !busy_flag)
    else $error("hold reset did not abort");
  c_busy_done: cover property ($fell(busy_flag));
  c_quad_on: cover property ($rose(io23_data_mode));
  c_hold_abort: cover property (busy_flag && !hold_rst_n);
endmodule : fsw_status_protect_props

bind fsw_status_protect fsw_status_protect_props #(
  .PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES),
  .NVREG_CYCLES(NVREG_CYCLES)
) i_props (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .spi_sck(spi_sck),
  .spi_cs_n(spi_cs_n),
  .spi_mosi(spi_mosi),
  .wp_n(wp_n),
  .hold_rst_n(hold_rst_n),
  .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe),
  .io23_data_mode(io23_data_mode),
  .busy_flag(busy_flag)
);

// file: verification/fsw_host_model.sv
`timescale 1ns/1ps
module fsw_host_model (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // Half of the 125 ns link clock
  localparam realtime HALF = 62.5;
  // Link clock stands low and select high between frames
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Mode 0 frame: bytes out MSB first, then nrd bytes in
  task automatic frame(input logic [7:0] tx[$], input int nrd, output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    #(2 * HALF);
    spi_cs_n = 1'b0;
    #HALF;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        spi_sck = 1'b0;
        spi_mosi = tx[i][k];
        #HALF;
        spi_sck = 1'b1;
        #HALF;
      end
    end
    repeat (nrd) begin
      // Sampled at the rise, long after the device's fall update
      for (int k = 7; k >= 0; k--) begin
        spi_sck = 1'b0;
        #HALF;
        spi_sck = 1'b1;
        b[k] = spi_miso;
        #HALF;
      end
      rx.push_back(b);
    end
    spi_sck = 1'b0;
    #HALF;
    spi_cs_n = 1'b1;
    // Idle data line flips so no stale bit can pass for data
    spi_mosi = ~spi_mosi;
  endtask : frame
endmodule : fsw_host_model

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench
  import fsw_pkg::*;
;
  typedef logic [7:0] fsw_bytes_t[$];
  localparam int TIMEOUT = 98000;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic hold_rst_n = 1'b1;
  logic spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, io23_data_mode, busy_flag;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  fsw_bytes_t rx;
  logic [31:0] dw;
  // Every latch-gated write code
  logic [7:0] ops[16] = '{CMD_PAGE_PROGRAM, CMD_QUAD_PAGE_PROGRAM_A, CMD_QUAD_PAGE_PROGRAM_B,
    CMD_INFO_ROW_PROGRAM, CMD_SECTOR_ERASE_A, CMD_SECTOR_ERASE_B, CMD_ERASE_32K, CMD_ERASE_64K,
    CMD_FULL_ERASE_A, CMD_FULL_ERASE_B, CMD_STATUS_WRITE, CMD_FUNCTION_WRITE, CMD_READPARAM_NV,
    CMD_EXT_READPARAM_NV, CMD_INFO_ROW_ERASE, CMD_BOOT_REG_WRITE};
  // Protect field, target block, erase expected to run
  logic [7:0] pd[6] = '{8'h06, 8'h06, 8'h22, 8'h26, 8'h26, 8'h3E};
  logic [7:0] pa[6] = '{8'h3F, 8'h3E, 8'h00, 8'h1F, 8'h20, 8'h00};
  logic pb[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  always #4 sys_clk = ~sys_clk;
  fsw_status_protect #(.PROG_CYCLES(20), .ERASE_CYCLES(1000), .NVREG_CYCLES(10))
    i_fsw_status_protect (.sys_clk(sys_clk), .rst_n(rst_n), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .wp_n(wp_n), .hold_rst_n(hold_rst_n),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .io23_data_mode(io23_data_mode),
    .busy_flag(busy_flag));
  // Undriven line shows the inverse of its last bit, so a read without enable fails
  logic host_miso;
  assign host_miso = spi_miso_oe ? spi_miso : ~spi_miso;
  fsw_host_model host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(host_miso));
  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Frame length follows the opcode's class
  function automatic fsw_bytes_t build(input logic [7:0] op, input logic [7:0] a);
    case (op)
      CMD_FULL_ERASE_A, CMD_FULL_ERASE_B: return {op};
      CMD_STATUS_WRITE, CMD_FUNCTION_WRITE, CMD_READPARAM_NV, CMD_EXT_READPARAM_NV,
        CMD_BOOT_REG_WRITE: return {op, a};
      CMD_PAGE_PROGRAM, CMD_QUAD_PAGE_PROGRAM_A, CMD_QUAD_PAGE_PROGRAM_B,
        CMD_INFO_ROW_PROGRAM: return {op, a, 8'h00, 8'h00, 8'h5A};
      default: return {op, a, 8'h00, 8'h00};
    endcase
  endfunction : build
  task automatic send(input fsw_bytes_t tx);
    fsw_bytes_t r;
    host.frame(tx, 0, r);
  endtask : send
  task automatic rd(input int n);
    host.frame({CMD_STATUS_READ}, n, rx);
  endtask : rd
  // Busy must start or stay off, then clear within a bound
  task automatic wait_done(input logic exp);
    int n;
    n = 0;
    repeat (8) @(negedge sys_clk);
    check("busy start", {7'h00, busy_flag}, {7'h00, exp});
    while (busy_flag !== 1'b0 && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    check("busy idle", {7'h00, busy_flag}, 8'h00);
  endtask : wait_done
  task automatic wr_status(input logic [7:0] d);
    send({CMD_WRITE_ENABLE});
    send({CMD_STATUS_WRITE, d});
    wait_done(1'b1);
  endtask : wr_status
  task automatic set_wp(input logic v);
    @(negedge sys_clk);
    wp_n = v;
  endtask : set_wp
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    // Reset value, byte repeated
    rd(3);
    foreach (rx[i]) check("status reset", rx[i], STATUS_RESET);
    check("quad pins", {7'h00, io23_data_mode}, 8'h00);
    send({CMD_WRITE_ENABLE});
    rd(2);
    check("latch set", rx[1], 8'h02);
    send({CMD_WRITE_DISABLE});
    rd(1);
    check("latch clear", rx[0], 8'h00);
    // Each gated write without, then with, the latch
    for (int w = 0; w < 2; w++) begin
      foreach (ops[i]) begin
        if (w == 1) send({CMD_WRITE_ENABLE});
        send(build(ops[i], 8'h00));
        wait_done(w[0]);
        rd(1);
        check("after write", rx[0], 8'h00);
      end
    end
    // Protect field against target block
    for (int i = 0; i < 6; i++) begin
      wr_status(pd[i]);
      rd(1);
      check("protect field", rx[0], pd[i] & 8'h3C);
      send({CMD_WRITE_ENABLE});
      send(build(CMD_ERASE_64K, pa[i]));
      wait_done(pb[i]);
    end
    send({CMD_WRITE_ENABLE});
    send({CMD_FULL_ERASE_A});
    wait_done(1'b0);
    // Lock with pin low, then pin high, then quad mode
    wr_status(8'h80);
    set_wp(1'b0);
    send({CMD_WRITE_ENABLE});
    send({CMD_STATUS_WRITE, 8'h3C});
    wait_done(1'b0);
    rd(1);
    check("locked", rx[0], 8'h82);
    set_wp(1'b1);
    wr_status(8'hC0);
    rd(1);
    check("unlocked", rx[0], 8'hC0);
    check("quad pins", {7'h00, io23_data_mode}, 8'h01);
    set_wp(1'b0);
    wr_status(8'h00);
    rd(1);
    check("quad off", {7'h00, io23_data_mode}, 8'h00);
    set_wp(1'b1);
    // Live busy across a long erase, disable ignored
    send({CMD_WRITE_ENABLE});
    send(build(CMD_ERASE_64K, 8'h00));
    send({CMD_WRITE_DISABLE});
    rd(12);
    check("busy first", rx[0], 8'h03);
    check("busy last", rx[11], 8'h00);
    // Suspend and resume mid-erase
    send({CMD_WRITE_ENABLE});
    send(build(CMD_ERASE_64K, 8'h00));
    send({CMD_SUSPEND});
    wait_done(1'b0);
    send({CMD_RESUME});
    wait_done(1'b1);
    rd(1);
    check("resumed", rx[0], 8'h00);
    // Volatile write runs without latch; read and reset taken while busy
    send({8'hC0, 8'h00});
    wait_done(1'b0);
    send({CMD_WRITE_ENABLE});
    send(build(CMD_ERASE_64K, 8'h00));
    host.frame({CMD_FUNC_READ}, 2, rx);
    check("function read", rx[1], 8'h00);
    send({CMD_RESET});
    wait_done(1'b0);
    rd(1);
    check("after reset", rx[0], 8'h00);
    // Hold pin aborts a running erase
    send({CMD_WRITE_ENABLE});
    send(build(CMD_ERASE_64K, 8'h00));
    repeat (20) @(negedge sys_clk);
    hold_rst_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    check("hold abort", {7'h00, busy_flag}, 8'h00);
    hold_rst_n = 1'b1;
    rd(1);
    check("hold latch", rx[0], 8'h00);
    // Parameter table dword and quad requirement
    dw = {1'b0, DPD_ENTRY_CODE, DPD_EXIT_CODE, 15'h7FFF};
    host.frame({CMD_PARAM_TABLE_READ, 8'h00, 8'h00, PT_ADDR_DPD_0, 8'h00}, 6, rx);
    for (int i = 0; i < 3; i++) check("table dword", rx[i], dw[8*i+8 +: 8]);
    check("table quad", {5'h00, rx[5][6:4]}, {5'h00, QUAD_ENABLE_REQUIREMENT});
    give_verdict();
  end
endmodule : testbench
